/* core/cte_pkg.sv */
package cte_pkg;

  // ==========================================================================
  // Opcode families and single-byte codes.
  // ==========================================================================
  localparam logic [7:0] OP_HALT = 8'h00;
  localparam logic [7:0] OP_CCL = 8'h02;
  localparam logic [7:0] OP_SCL = 8'h03;
  localparam logic [7:0] OP_DISABLE_INTERRUPT_OP = 8'h04;
  localparam logic [7:0] OP_IEN = 8'h05;
  localparam logic [7:0] OP_CSA = 8'h06;
  localparam logic [7:0] OP_CAS = 8'h07;
  localparam logic [7:0] OP_NOP = 8'h08;
  localparam logic [7:0] OP_SIO = 8'h19;
  localparam logic [7:0] OP_SR = 8'h1c;
  localparam logic [7:0] OP_SRL = 8'h1d;
  localparam logic [7:0] OP_RR = 8'h1e;
  localparam logic [7:0] OP_RRL = 8'h1f;
  localparam logic [7:0] OP_DLY = 8'h8f;
  localparam logic [5:0] FAM_SWAP_ACC_POINTER_LOW = 6'h0c;
  localparam logic [5:0] FAM_SWAP_ACC_POINTER_HIGH = 6'h0d;
  localparam logic [5:0] FAM_SWAP_POINTER_WITH_COUNTER = 6'h0f;
  localparam logic [5:0] FAM_JMP = 6'h24;
  localparam logic [5:0] FAM_JP = 6'h25;
  localparam logic [5:0] FAM_JZ = 6'h26;
  localparam logic [5:0] FAM_JNZ = 6'h27;
  localparam logic [5:0] FAM_ILD = 6'h2a;
  localparam logic [5:0] FAM_DLD = 6'h2e;

  // ==========================================================================
  // Status byte bit positions.
  // ==========================================================================
  localparam int ST_CY = 7;
  localparam int ST_OV = 6;
  localparam int ST_SB = 5;
  localparam int ST_SA = 4;
  localparam int ST_IE = 3;

  // ==========================================================================
  // Microcycle budgets; one microcycle is one clk_sys_in cycle here.
  // ==========================================================================
  localparam logic [7:0] MC_SHORT = 8'h05;
  localparam logic [7:0] MC_IE = 8'h06;
  localparam logic [7:0] MC_CAS = 8'h06;
  localparam logic [7:0] MC_SWAP_POINTER_WITH_COUNTER = 8'h07;
  localparam logic [7:0] MC_XPA = 8'h08;
  localparam logic [7:0] MC_HALT = 8'h08;
  localparam logic [7:0] MC_JNT = 8'h09;
  localparam logic [7:0] MC_JT = 8'h0b;
  localparam logic [7:0] MC_IDL = 8'h16;
  localparam logic [7:0] MC_DLY_BASE = 8'h0d;
  localparam logic [9:0] MC_DLY_STEP = 10'h202;
  localparam logic [7:0] ACC_AFTER_DLY = 8'hff;

  typedef struct packed {
    logic rd;
    logic wr;
    logic hold;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cte_bus_t;

endpackage : cte_pkg

/* core/cte_exec.sv */
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// What this block does
// RULE_01: Count-and-load ops write the result to memory and the accumulator.
// RULE_02: Increment/decrement-and-load leave the carry/link flag untouched.
// RULE_03: Jump always loads EA; others test nonnegative, zero, nonzero.
// RULE_04: Field zero is counter-relative, else pointer plus signed disp.
// RULE_05: Jump-if-nonnegative tests only accumulator bit seven being zero.
// RULE_06: Pointer-low/high swaps exchange accumulator with pointer byte.
// RULE_07: Counter swap exchanges the whole pointer and program counter.
// RULE_08: Program counter increments before every fetch.
// RULE_09: Serial shift moves extension right, input into bit 7, bit 0 out.
// RULE_10: Right shift, shift with carry, rotate, rotate through carry.
// RULE_11: Delay stalls 13 + 2*AC + 514*disp microcycles.
// RULE_12: After the delay the accumulator holds all ones.
// RULE_13: Halt pulses the halt flag, otherwise acts as no-operation.
// RULE_14: 02 to 08 clear/set carry, interrupt off/on, status moves, nop.
// RULE_15: Status copied to accumulator carries the carry flag in bit 7.
// RULE_16: Each instruction takes its listed reads, writes and microcycles.
// RULE_17: Status holds carry, overflow, two sense inputs, enable, three flags.
// RULE_18: Bus stays owned from increment/decrement read to write back.
// RULE_19: Pointer select is opcode bits 1:0; upper bits name the family.
module cte_exec (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic sense_a_in,
  input wire logic sense_b_in,
  input wire logic serial_input_pin_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic bus_hold_out,
  output logic address_strobe_n_out,
  output logic halt_flag_out,
  output logic serial_output_pin_out,
  output logic [7:0] accumulator_out,
  output logic [7:0] status_out,
  output logic [15:0] pc_out,
  output logic busy_out
);

  // ==========================================================================
  // State and registers.
  // ==========================================================================
  typedef enum logic [2:0] {
    CTE_FETCH = 3'b000,
    CTE_DISP = 3'b001,
    CTE_DATA = 3'b010,
    CTE_WAIT = 3'b011,
    CTE_WRITE = 3'b100
  } cte_state_t;

  cte_state_t state_q;
  logic [15:0] pc_q;
  logic [15:0] ptr_q [1:3];
  logic [7:0] acc_q;
  logic [7:0] ext_q;
  logic [7:0] stat_q;
  logic [7:0] op_q;
  logic [7:0] disp_q;
  logic [17:0] wait_q;
  logic [15:0] ea_q;
  cte_pkg::cte_bus_t bus_q;
  logic halt_q;
  logic serial_output_pin_q;

  // Base register for an opcode's pointer field; zero means the counter.
  function automatic logic [15:0] base_of(input logic [1:0] sel,
                                          input logic [15:0] pc,
                                          input logic [15:0] p1,
                                          input logic [15:0] p2,
                                          input logic [15:0] p3);
    case (sel) // RULE_19
      2'd1: base_of = p1;
      2'd2: base_of = p2;
      2'd3: base_of = p3;
      default: base_of = pc; // RULE_04
    endcase
  endfunction : base_of

  // Signed displacement added to a 16-bit base.
  function automatic logic [15:0] add_disp(input logic [15:0] b,
                                           input logic [7:0] d);
    add_disp = b + {{8{d[7]}}, d}; // RULE_04
  endfunction : add_disp

  // Opcodes that carry a second byte: the upper half of the map and halt.
  function automatic logic two_byte(input logic [7:0] op);
    two_byte = op[7] || (op == cte_pkg::OP_HALT);
  endfunction : two_byte

  // Increment- and decrement-and-load share one read-modify-write path.
  function automatic logic is_count(input logic [7:0] op);
    is_count = (op[7:2] == cte_pkg::FAM_ILD)
               || (op[7:2] == cte_pkg::FAM_DLD);
  endfunction : is_count

  logic [15:0] pc_next;
  logic [15:0] base_w;
  logic [15:0] base_op;
  logic [5:0] fam_w;
  logic [1:0] sel_w;
  logic [7:0] stat_live;

  // The counter steps ahead before each fetch, so a fetch reads pc + 1.
  assign pc_next = pc_q + 16'h0001; // RULE_08
  assign fam_w = op_q[7:2];
  assign sel_w = op_q[1:0];
  assign base_w = base_of(sel_w, pc_q, ptr_q[1], ptr_q[2], ptr_q[3]);
  // Base of the opcode now on the bus, for the pointer-low and pointer-high swaps.
  assign base_op = base_of(mem_rdata_in[1:0], pc_q, ptr_q[1], ptr_q[2],
                           ptr_q[3]);
  // Sense bits are live inputs; they are never stored.
  assign stat_live = {stat_q[7:6], sense_b_in, sense_a_in, stat_q[3:0]};

  // Jump condition evaluated on the accumulator as it stands.
  function automatic logic jump_taken(input logic [5:0] f,
                                      input logic [7:0] a);
    case (f) // RULE_03
      cte_pkg::FAM_JMP: jump_taken = 1'b1;
      cte_pkg::FAM_JP: jump_taken = ~a[7]; // RULE_05
      cte_pkg::FAM_JZ: jump_taken = (a == 8'h00);
      cte_pkg::FAM_JNZ: jump_taken = (a != 8'h00);
      default: jump_taken = 1'b0;
    endcase
  endfunction : jump_taken

  // ==========================================================================
  // Sequencer: fetch, operand fetch, execute, and microcycle padding.
  // ==========================================================================
  // The padding counter holds each instruction to its budget, counted from
  // its opcode fetch; a budget counts the fetch cycle itself.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CTE_FETCH;
      pc_q <= 16'h0000;
      ptr_q[1] <= 16'h0000;
      ptr_q[2] <= 16'h0000;
      ptr_q[3] <= 16'h0000;
      acc_q <= 8'h00;
      ext_q <= 8'h00;
      stat_q <= 8'h00;
      op_q <= 8'h00;
      disp_q <= 8'h00;
      wait_q <= 18'h00000;
      ea_q <= 16'h0000;
      bus_q <= '0;
      halt_q <= 1'b0;
      serial_output_pin_q <= 1'b0;
    end else begin
      bus_q.rd <= 1'b0;
      bus_q.wr <= 1'b0;
      halt_q <= 1'b0;
      case (state_q)
        CTE_FETCH: begin
          if (!bus_q.hold) begin
            pc_q <= pc_next; // RULE_08
            bus_q.addr <= pc_next;
            bus_q.rd <= 1'b1;
            state_q <= CTE_DISP;
          end
        end
        CTE_DISP: begin
          op_q <= mem_rdata_in;
          state_q <= CTE_WAIT;
          wait_q <= {10'h000, cte_pkg::MC_SHORT} - 18'd3; // RULE_16
          if (two_byte(mem_rdata_in)) begin
            // Two-byte forms read the second byte next. Halt pulses its
            // flag now, beside the strobe of that read, so that outside
            // logic sampling at strobe time sees it.
            halt_q <= (mem_rdata_in == cte_pkg::OP_HALT); // RULE_13
            pc_q <= pc_next;
            bus_q.addr <= pc_next;
            bus_q.rd <= 1'b1;
            state_q <= CTE_DATA;
          end else begin
            case (mem_rdata_in)
              cte_pkg::OP_CCL: stat_q[cte_pkg::ST_CY] <= 1'b0; // RULE_14
              cte_pkg::OP_SCL: stat_q[cte_pkg::ST_CY] <= 1'b1;
              cte_pkg::OP_DISABLE_INTERRUPT_OP: begin
                stat_q[cte_pkg::ST_IE] <= 1'b0;
                wait_q <= {10'h000, cte_pkg::MC_IE} - 18'd3;
              end
              cte_pkg::OP_IEN: begin
                stat_q[cte_pkg::ST_IE] <= 1'b1;
                wait_q <= {10'h000, cte_pkg::MC_IE} - 18'd3;
              end
              cte_pkg::OP_CSA: acc_q <= stat_live; // RULE_15 RULE_17
              cte_pkg::OP_CAS: begin
                // Sense bits are read-only, so their positions stay zero.
                stat_q <= {acc_q[7:6], 2'b00, acc_q[3:0]}; // RULE_17
                wait_q <= {10'h000, cte_pkg::MC_CAS} - 18'd3;
              end
              cte_pkg::OP_SIO: begin
                ext_q <= {serial_input_pin_in, ext_q[7:1]}; // RULE_09
                serial_output_pin_q <= ext_q[0];
              end
              cte_pkg::OP_SR: acc_q <= {1'b0, acc_q[7:1]}; // RULE_10
              cte_pkg::OP_SRL: acc_q <= {stat_q[cte_pkg::ST_CY], acc_q[7:1]};
              cte_pkg::OP_RR: acc_q <= {acc_q[0], acc_q[7:1]};
              cte_pkg::OP_RRL: begin
                acc_q <= {stat_q[cte_pkg::ST_CY], acc_q[7:1]};
                stat_q[cte_pkg::ST_CY] <= acc_q[0];
              end
              default: begin
                if (mem_rdata_in[7:2] == cte_pkg::FAM_SWAP_ACC_POINTER_LOW) begin
                  acc_q <= base_op[7:0]; // RULE_06
                  if (mem_rdata_in[1:0] != 2'd0)
                    ptr_q[mem_rdata_in[1:0]][7:0] <= acc_q;
                  else
                    pc_q[7:0] <= acc_q;
                  wait_q <= {10'h000, cte_pkg::MC_XPA} - 18'd3;
                end else if (mem_rdata_in[7:2] == cte_pkg::FAM_SWAP_ACC_POINTER_HIGH) begin
                  acc_q <= base_op[15:8]; // RULE_06
                  if (mem_rdata_in[1:0] != 2'd0)
                    ptr_q[mem_rdata_in[1:0]][15:8] <= acc_q;
                  else
                    pc_q[15:8] <= acc_q;
                  wait_q <= {10'h000, cte_pkg::MC_XPA} - 18'd3;
                end else if (mem_rdata_in[7:2] == cte_pkg::FAM_SWAP_POINTER_WITH_COUNTER) begin
                  if (mem_rdata_in[1:0] != 2'd0) begin
                    pc_q <= ptr_q[mem_rdata_in[1:0]]; // RULE_07
                    ptr_q[mem_rdata_in[1:0]] <= pc_q;
                  end
                  wait_q <= {10'h000, cte_pkg::MC_SWAP_POINTER_WITH_COUNTER} - 18'd3;
                end
              end
            endcase
          end
        end
        CTE_DATA: begin
          disp_q <= mem_rdata_in;
          state_q <= CTE_WAIT;
          wait_q <= {10'h000, cte_pkg::MC_JNT} - 18'd4;
          if (op_q == cte_pkg::OP_HALT) begin
            // The flag has already pulsed; only the budget is left.
            wait_q <= {10'h000, cte_pkg::MC_HALT} - 18'd4;
          end else if (op_q == cte_pkg::OP_DLY) begin
            // The accumulator takes minus one at once; only wait_q counts the stall.
            wait_q <= 18'({10'h000, cte_pkg::MC_DLY_BASE}
                      + {9'h000, acc_q, 1'b0}
                      + 28'(cte_pkg::MC_DLY_STEP) * 28'(mem_rdata_in))
                      - 18'd4; // RULE_11
            acc_q <= cte_pkg::ACC_AFTER_DLY; // RULE_12
          end else if (is_count(op_q)) begin
            ea_q <= add_disp(base_w, mem_rdata_in); // RULE_04
            bus_q.addr <= add_disp(base_w, mem_rdata_in);
            bus_q.rd <= 1'b1;
            bus_q.hold <= 1'b1; // RULE_18
            state_q <= CTE_WRITE;
          end else if (jump_taken(fam_w, acc_q)) begin
            pc_q <= add_disp(base_w, mem_rdata_in); // RULE_03
            wait_q <= {10'h000, cte_pkg::MC_JT} - 18'd4; // RULE_16
          end
        end
        CTE_WRITE: begin
          // The read byte is back; write the counted value, carry untouched.
          bus_q.wr <= 1'b1;
          bus_q.addr <= ea_q;
          if (op_q[7:2] == cte_pkg::FAM_ILD) begin
            bus_q.wdata <= mem_rdata_in + 8'h01; // RULE_01
            acc_q <= mem_rdata_in + 8'h01; // RULE_02
          end else begin
            bus_q.wdata <= mem_rdata_in - 8'h01; // RULE_01
            acc_q <= mem_rdata_in - 8'h01; // RULE_02
          end
          // Fetch, operand, data read and this write make four edges; the wait exit is the fifth.
          wait_q <= {10'h000, cte_pkg::MC_IDL} - 18'd5; // RULE_16
          state_q <= CTE_WAIT;
        end
        CTE_WAIT: begin
          // Release the bus only after the write back has been issued.
          bus_q.hold <= 1'b0; // RULE_18
          if (wait_q == 18'h00000) begin
            state_q <= CTE_FETCH; // RULE_16
          end else begin
            wait_q <= wait_q - 18'h00001;
          end
        end
        default: state_q <= CTE_FETCH;
      endcase
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops.
  // ==========================================================================
  // Address strobe goes low in the same cycle as every read or write
  // request, the data read of a counting instruction included.
  logic strobe_n_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_n_q <= 1'b1;
    end else begin
      strobe_n_q <= ~((state_q == CTE_FETCH && !bus_q.hold)
                      || (state_q == CTE_DISP && two_byte(mem_rdata_in))
                      || (state_q == CTE_DATA && is_count(op_q))
                      || state_q == CTE_WRITE); // RULE_13
    end
  end

  // Busy is registered so it leaves from a flop; it follows the
  // sequencer's next state and drops only when a fetch is due.
  logic busy_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= !((state_q == CTE_WAIT && wait_q == 18'h00000)
                  || (state_q == CTE_FETCH && bus_q.hold));
    end
  end

  assign mem_addr_out = bus_q.addr;
  assign mem_rd_out = bus_q.rd;
  assign mem_wr_out = bus_q.wr;
  assign mem_wdata_out = bus_q.wdata;
  assign bus_hold_out = bus_q.hold;
  assign address_strobe_n_out = strobe_n_q;
  assign halt_flag_out = halt_q; // RULE_13
  assign serial_output_pin_out = serial_output_pin_q; // RULE_09
  assign accumulator_out = acc_q;
  assign status_out = stat_q;
  assign pc_out = pc_q;
  assign busy_out = busy_q;

endmodule : cte_exec

/* dv/cte_exec_monitor.sv */
`timescale 1ns/1ps
// ============================================================================
// Port-level checks on the execution core's bus and flag outputs.
// ============================================================================
module cte_exec_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic bus_hold_out,
  input wire logic address_strobe_n_out,
  input wire logic halt_flag_out,
  input wire logic [7:0] accumulator_out,
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // A read and a write never share a cycle on the single bus.
  property p_one_strobe;
    !(mem_rd_out && mem_wr_out);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobes high together");

  // The write-back of a counting instruction is a single cycle.
  property p_wr_pulse;
    mem_wr_out |=> !mem_wr_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");

  // The bus must still be held when the result goes back to memory.
  property p_wr_under_hold;
    mem_wr_out |-> bus_hold_out;
  endproperty
  a_wr_under_hold: assert property (p_wr_under_hold)
    else $error("write back without bus hold");

  // Taking the bus is only allowed for a read-modify-write, so it ends in one.
  property p_hold_ends_in_write;
    $rose(bus_hold_out) |-> ##[1:30] mem_wr_out;
  endproperty
  a_hold_ends_in_write: assert property (p_hold_ends_in_write)
    else $error("bus hold without a following write");

  // Counting loops depend on carry surviving the increment or decrement.
  property p_hold_keeps_carry;
    bus_hold_out |=> $stable(status_out[7]);
  endproperty
  a_hold_keeps_carry: assert property (p_hold_keeps_carry)
    else $error("carry changed during increment or decrement");

  // The value written back is also the one left in the accumulator.
  property p_wr_to_acc;
    mem_wr_out |-> ##[0:2] (accumulator_out == mem_wdata_out);
  endproperty
  a_wr_to_acc: assert property (p_wr_to_acc)
    else $error("accumulator differs from written value");

  // The halt flag is a pulse, not a level.
  property p_halt_pulse;
    halt_flag_out |=> !halt_flag_out;
  endproperty
  a_halt_pulse: assert property (p_halt_pulse)
    else $error("halt flag longer than one cycle");

  // Apart from its pulse, halt leaves the working registers alone.
  property p_halt_nop;
    halt_flag_out |=> $stable(accumulator_out) [*2];
  endproperty
  a_halt_nop: assert property (p_halt_nop)
    else $error("halt changed the accumulator");

  // Outside logic samples halt at address-strobe time, so each bus
  // request must carry that strobe in its own cycle.
  property p_strobe_follows;
    (mem_rd_out || mem_wr_out) |-> !address_strobe_n_out;
  endproperty
  a_strobe_follows: assert property (p_strobe_follows)
    else $error("no address strobe with bus request");

  // The halt pulse is only usable if it falls inside a strobe.
  property p_halt_at_strobe;
    halt_flag_out |-> !address_strobe_n_out;
  endproperty
  a_halt_at_strobe: assert property (p_halt_at_strobe)
    else $error("halt flag outside an address strobe");
endmodule : cte_exec_monitor

/* dv/cte_mem_model.sv */
`timescale 1ns/1ps
// ============================================================================
// Program and data memory answering within the cycle of each read pulse.
// ============================================================================
module cte_mem_model (
  input wire logic clk_sys_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out
);
  logic [7:0] mem [0:255];
  logic [7:0] idle_q = 8'h5a;

  // The core takes read data at the edge that ends its read pulse, so the
  // byte must stand during that pulse. Between reads the lines toggle, so
  // a core sampling a released bus picks up garbage, not a stale byte.
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in[7:0]] : idle_q;

  always @(posedge clk_sys_in) begin
    idle_q <= ~idle_q;
    if (mem_wr_in) mem[mem_addr_in[7:0]] <= mem_wdata_in;
  end
endmodule : cte_mem_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic sense_a_in = 1'b1;
  logic sense_b_in = 1'b0;
  logic serial_input_pin_in = 1'b1;
  logic [7:0] mem_rdata_in, mem_wdata_out, accumulator_out, status_out;
  logic [15:0] mem_addr_out, pc_out;
  logic mem_rd_out, mem_wr_out, bus_hold_out, address_strobe_n_out;
  logic halt_flag_out, serial_output_pin_out, busy_out;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int halts = 0;
  int t0;
  int last_fetch = 0;
  logic [7:0] prog [0:46] = '{8'h08, 8'h03, 8'ha8, 8'h5d, 8'hb8, 8'h5b,
    8'h1f, 8'h1c, 8'h1d, 8'h1e, 8'h94, 8'h02, 8'h02, 8'h06, 8'h94, 8'h01,
    8'h08, 8'h98, 8'h02, 8'h9c, 8'h01, 8'h08, 8'h05, 8'h04, 8'h00, 8'h19,
    8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h08,
    8'ha8, 8'h3c, 8'h33, 8'h37, 8'h3f, 8'h33, 8'h8f, 8'h01, 8'h07, 8'h90,
    8'hfd};
  logic [7:0] acc_exp [0:4] = '{8'h7f, 8'hbf, 8'h5f, 8'haf, 8'hd7};

  always #4 clk_sys_in = ~clk_sys_in;

  // Cycle count for the delay measurement and a tally of halt pulses.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (halt_flag_out === 1'b1) halts <= halts + 1;
  end

  cte_exec u_cte_exec (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .mem_rdata_in(mem_rdata_in), .sense_a_in(sense_a_in),
    .sense_b_in(sense_b_in), .serial_input_pin_in(serial_input_pin_in),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
    .bus_hold_out(bus_hold_out),
    .address_strobe_n_out(address_strobe_n_out),
    .halt_flag_out(halt_flag_out),
    .serial_output_pin_out(serial_output_pin_out),
    .accumulator_out(accumulator_out), .status_out(status_out),
    .pc_out(pc_out), .busy_out(busy_out));

  cte_mem_model u_cte_mem_model (.clk_sys_in(clk_sys_in),
    .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_rdata_out(mem_rdata_in));

  // ==========================================================================
  // Shared checks and the closing verdict.
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for the opcode read at the given address; operand reads elsewhere
  // are skipped, so a wrong branch shows up as a missed fetch or as a
  // wrong count n of cycles since the last matched fetch (0: not checked).
  task automatic fetch(input logic [15:0] a, input int n);
    int i;
    for (i = 0; i < 900; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (mem_rd_out === 1'b1 && mem_addr_out === a) break;
    end
    chk("fetch address", a, mem_addr_out);
    chk("program counter", a, pc_out);
    chk("busy", 16'h0001, 16'(busy_out));
    if (n > 0) chk("cycles", 16'(n), 16'(cyc - last_fetch));
    last_fetch = cyc;
  endtask : fetch

  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Program walk; each fetch is a point where the previous opcode is done.
  // ==========================================================================
  initial begin
    for (int i = 0; i < 256; i++) u_cte_mem_model.mem[i] = 8'h08;
    for (int i = 0; i < 47; i++) u_cte_mem_model.mem[i] = prog[i];
    u_cte_mem_model.mem[8'h40] = 8'h3f;
    u_cte_mem_model.mem[8'h60] = 8'h7f;
    u_cte_mem_model.mem[8'h61] = 8'h3e;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    fetch(16'h0004, 0);
    chk("acc inc", 16'h0080, 16'(accumulator_out));
    chk("mem inc", 16'h0080, 16'(u_cte_mem_model.mem[8'h60]));
    chk("carry kept", 16'h0001, 16'(status_out[7]));
    for (int k = 0; k < 5; k++) begin
      fetch(16'h0006 + 16'(k), (k == 0) ? 22 : 5);
      chk("acc shift", 16'(acc_exp[k]), 16'(accumulator_out));
    end
    chk("mem dec", 16'h007f, 16'(u_cte_mem_model.mem[8'h60]));
    fetch(16'h000c, 9);
    fetch(16'h000e, 10);
    chk("status copy", 16'h0010, 16'(accumulator_out));
    fetch(16'h0011, 11);
    fetch(16'h0013, 9);
    fetch(16'h0016, 11);
    fetch(16'h0017, 6);
    chk("ie set", 16'h0001, 16'(status_out[3]));
    fetch(16'h0018, 6);
    chk("ie clear", 16'h0000, 16'(status_out[3]));
    fetch(16'h001a, 8);
    chk("halt pulses", 16'h0001, 16'(halts));
    fetch(16'h0021, 35);
    chk("serial out", 16'h0000, 16'(serial_output_pin_out));
    fetch(16'h0023, 10);
    chk("serial out", 16'h0001, 16'(serial_output_pin_out));
    fetch(16'h0026, 27);
    chk("acc inc", 16'h003f, 16'(accumulator_out));
    fetch(16'h0028, 16);
    fetch(16'h0040, 7);
    fetch(16'h0029, 7);
    fetch(16'h002a, 8);
    chk("acc swap low", 16'h0040, 16'(accumulator_out));
    t0 = cyc;
    fetch(16'h002c, 655);
    chk("delay length", 16'h0001,
        16'((cyc - t0) >= 650 && (cyc - t0) <= 670));
    chk("acc after delay", 16'h00ff, 16'(accumulator_out));
    fetch(16'h002d, 6);
    chk("status load", 16'h003f,
        16'({status_out[7:6], status_out[3:0]}));
    fetch(16'h002c, 11);
    stop_test();
  end

  // A hang anywhere ends the run with a mismatch.
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    mismatches++;
    stop_test();
  end
endmodule : tb_top

bind cte_exec cte_exec_monitor u_cte_exec_monitor (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
  .bus_hold_out(bus_hold_out), .address_strobe_n_out(address_strobe_n_out),
  .halt_flag_out(halt_flag_out), .accumulator_out(accumulator_out),
  .status_out(status_out));
